// >>> inc/cwtd_pkg.sv
// Constants for the channel window limit and fault filter block
package cwtd_pkg;
   // Register offsets on the serial host port
   localparam logic [7:0] ADDR_UNDER = 8'h52;
   localparam logic [7:0] ADDR_OVER = 8'h53;
   localparam logic [7:0] ADDR_FILT = 8'h54;
   // Reset values (undefined in hardware, zero chosen)
   localparam logic [7:0] RESET_LIMIT = 8'h00;
   localparam logic [7:0] RESET_FILT = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   // Field positions of the filter register
   localparam int OVER_SEL_HI = 7;
   localparam int OVER_SEL_LO = 4;
   localparam int UNDER_SEL_HI = 3;
   localparam int UNDER_SEL_LO = 0;
   // Limit code to millivolt mapping
   localparam int MV_W = 16;
   localparam logic [MV_W-1:0] BASE_1X_MV = 16'h00c8;
   localparam logic [MV_W-1:0] STEP_1X_MV = 16'h0005;
   localparam logic [MV_W-1:0] BASE_4X_MV = 16'h0320;
   localparam logic [MV_W-1:0] STEP_4X_MV = 16'h0014;
   // Filter timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int DEB_BASE_NS = 100;
   localparam int DEB_BASE_CYC_I =
      (DEB_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 13;
   localparam logic [CNT_W-1:0] DEB_BASE_CYC = CNT_W'(DEB_BASE_CYC_I);
   localparam logic [3:0] DEB_CODE_CAP = 4'ha;
   localparam logic [CNT_W-1:0] CNT_ONE = 13'h0001;
endpackage

// >>> inc/deb_if.sv
// Carrier between the top and one fault filter
`timescale 1ns/100ps
interface deb_if;
   logic raw;
   logic [3:0] code;
   logic filtered;
   modport filter (input raw, input code, output filtered);
   modport user (output raw, output code, input filtered);
endinterface

// >>> hw/fault_filter.sv
// One comparator output filter with selectable stable time
`timescale 1ns/100ps
module fault_filter
   import cwtd_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Comparator side
   deb_if.filter link
);
   logic [3:0] capCode;
   logic [CNT_W-1:0] target;
   logic lastRaw_r;
   logic [CNT_W-1:0] stable_r;
   logic filtered_r;

   // Codes above the cap all select the longest time
   always_comb begin
      capCode = (link.code > DEB_CODE_CAP) ? DEB_CODE_CAP : link.code;
      target = DEB_BASE_CYC << capCode;
   end

   // Previous input sample
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         lastRaw_r <= 1'b0;
      end else begin
         lastRaw_r <= link.raw;
      end
   end

   // Cycles for which the input has kept its value
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         stable_r <= '0;
      end else if (link.raw != lastRaw_r) begin
         stable_r <= '0;
      end else if (stable_r < target) begin
         stable_r <= stable_r + CNT_ONE;
      end
   end

   // Output follows the input only once it held for the whole time
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         filtered_r <= 1'b0;
      end else if (link.raw == lastRaw_r && stable_r + CNT_ONE >= target) begin
         filtered_r <= link.raw;
      end
   end

   assign link.filtered = filtered_r;
endmodule

// >>> hw/channel_window_threshold_debounce.sv
// Channel limit registers, voltage mapping and fast path fault filters
`timescale 1ns/100ps
module channel_window_threshold_debounce
   import cwtd_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Register port from the serial host interface
   input wire logic [7:0] regAddr,
   input wire logic regWrEn,
   input wire logic [7:0] regWrData,
   input wire logic regRdEn,
   output logic [7:0] regRdData,
   output logic regRdValid,
   // Range scaling, high selects 4x
   input wire logic rangeScalingSelect,
   // Fast path comparator outputs
   input wire logic overCompare,
   input wire logic underCompare,
   // Filtered faults
   output logic overFault,
   output logic underFault,
   // Slow path limits, as codes and in millivolts
   output logic [7:0] underLimitCode,
   output logic [7:0] overLimitCode,
   output logic [MV_W-1:0] underLimitMv,
   output logic [MV_W-1:0] overLimitMv
);
   // Stored limits and fast path filter selection; their power-up
   // value is undefined, so reset clears them to make reads repeatable
   logic [7:0] underLimit_r;
   logic [7:0] overLimit_r;
   logic [7:0] filtSel_r;

   // Offset decode and write strobes
   logic hitUnder;
   logic hitOver;
   logic hitFilt;
   logic wrUnder;
   logic wrOver;
   logic wrFilt;

   // Read path
   logic [7:0] rdData_nxt;
   logic [7:0] rdData_r;
   logic rdData_vld_r;

   // Millivolt view of the limits
   logic [MV_W-1:0] mvBase;
   logic [MV_W-1:0] mvStep;
   logic [MV_W-1:0] underMv_nxt;
   logic [MV_W-1:0] overMv_nxt;
   logic [MV_W-1:0] underMv_r;
   logic [MV_W-1:0] overMv_r;

   // Filter time selections and one carrier per comparator filter
   logic [3:0] overSel;
   logic [3:0] underSel;
   deb_if overLink ();
   deb_if underLink ();

   // Offset decode, shared by the write and read sides
   always_comb begin
      hitUnder = (regAddr == ADDR_UNDER);
      hitOver = (regAddr == ADDR_OVER);
      hitFilt = (regAddr == ADDR_FILT);
   end

   // Write strobes; other offsets of the host map fall through
   // here, so neighbouring registers never alias into this channel
   always_comb begin
      wrUnder = regWrEn && hitUnder;
      wrOver = regWrEn && hitOver;
      wrFilt = regWrEn && hitFilt;
   end

   // Slow path undervoltage limit
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         underLimit_r <= RESET_LIMIT;
      end else if (wrUnder) begin
         underLimit_r <= regWrData;
      end
   end

   // Slow path overvoltage limit
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         overLimit_r <= RESET_LIMIT;
      end else if (wrOver) begin
         overLimit_r <= regWrData;
      end
   end

   // Filter selection, both nibbles written in one access
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         filtSel_r <= RESET_FILT;
      end else if (wrFilt) begin
         filtSel_r <= regWrData;
      end
   end

   // Read data select; a read in the same cycle as a write
   // to that offset returns the value from before the write
   always_comb begin
      rdData_nxt = READ_UNMAPPED; // Unmapped offsets
      if (hitUnder) begin
         rdData_nxt = underLimit_r;
      end
      if (hitOver) begin
         rdData_nxt = overLimit_r;
      end
      if (hitFilt) begin
         rdData_nxt = filtSel_r;
      end
   end

   // Read valid, a single cycle pulse after each strobe; a strobe
   // held high for several cycles gives one answer per cycle
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rdData_vld_r <= 1'b0;
      end else begin
         rdData_vld_r <= regRdEn;
      end
   end

   // Read data, held until the next read strobe so a slow host
   // can still pick it up after the valid pulse has gone
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rdData_r <= READ_UNMAPPED;
      end else if (regRdEn) begin
         rdData_r <= rdData_nxt;
      end
   end

   // Base and step of the code meaning; the range setting is a
   // plain level, so switching it reinterprets both stored limits
   always_comb begin
      if (rangeScalingSelect) begin
         mvBase = BASE_4X_MV;
         mvStep = STEP_4X_MV;
      end else begin
         mvBase = BASE_1X_MV;
         mvStep = STEP_1X_MV;
      end
   end

   // Limit code to millivolts; the widest result fits in 16 bits
   always_comb begin
      underMv_nxt = mvBase + MV_W'(underLimit_r) * mvStep;
      overMv_nxt = mvBase + MV_W'(overLimit_r) * mvStep;
   end

   // Registered undervoltage limit in millivolts
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         underMv_r <= '0;
      end else begin
         underMv_r <= underMv_nxt;
      end
   end

   // Registered overvoltage limit in millivolts
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         overMv_r <= '0;
      end else begin
         overMv_r <= overMv_nxt;
      end
   end

   // Split the filter register into its two time selections
   always_comb begin
      overSel = filtSel_r[OVER_SEL_HI:OVER_SEL_LO];
      underSel = filtSel_r[UNDER_SEL_HI:UNDER_SEL_LO];
   end

   // Each filter restarts on any change of its comparator, so
   // excursions shorter than the selected time never reach a fault
   // Overvoltage comparator into its filter
   assign overLink.raw = overCompare;
   assign overLink.code = overSel;

   // Undervoltage comparator into its filter
   assign underLink.raw = underCompare;
   assign underLink.code = underSel;

   // Overvoltage fast path filter
   fault_filter overFilter (
      .clk(clk),
      .reset_n(reset_n),
      .link(overLink)
   );

   // Undervoltage fast path filter
   fault_filter underFilter (
      .clk(clk),
      .reset_n(reset_n),
      .link(underLink)
   );

   // Filtered faults, straight from the filter flip-flops
   assign overFault = overLink.filtered;
   assign underFault = underLink.filtered;

   // Register read port
   assign regRdData = rdData_r;
   assign regRdValid = rdData_vld_r;

   // Limit codes
   assign underLimitCode = underLimit_r;
   assign overLimitCode = overLimit_r;

   // Limits in millivolts, one cycle behind code and scale
   assign underLimitMv = underMv_r;
   assign overLimitMv = overMv_r;
endmodule

// >>> tb/cwtd_monitor.sv
// Checker for limit registers, mapping and fault filters
`timescale 1ns/100ps
module cwtd_monitor
   import cwtd_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic regWrEn,
   input wire logic [7:0] regWrData,
   input wire logic regRdEn,
   input wire logic [7:0] regRdData,
   input wire logic regRdValid,
   // Scaling, comparators and faults
   input wire logic rangeScalingSelect,
   input wire logic overCompare,
   input wire logic underCompare,
   input wire logic overFault,
   input wire logic underFault,
   // Limits
   input wire logic [7:0] underLimitCode,
   input wire logic [7:0] overLimitCode,
   input wire logic [MV_W-1:0] underLimitMv,
   input wire logic [MV_W-1:0] overLimitMv
);
   logic [7:0] flt_r;
   logic [15:0] run_r;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Shadow of the filter select register
   always_ff @(posedge clk) begin
      if (!reset_n) flt_r <= 8'h00;
      else if (regWrEn && regAddr == ADDR_FILT) flt_r <= regWrData;
   end
   // Length of the current high run on the over input
   always_ff @(posedge clk) begin
      if (!reset_n || !overCompare) run_r <= 16'h0000;
      else run_r <= run_r + 16'h0001;
   end
   a_under_write: assert property (
      regWrEn && regAddr == ADDR_UNDER |=>
      underLimitCode == $past(regWrData)) else $error("under write lost");
   a_over_write: assert property (
      regWrEn && regAddr == ADDR_OVER |=>
      overLimitCode == $past(regWrData)) else $error("over write lost");
   a_over_read: assert property (
      regRdEn && regAddr == ADDR_OVER |=>
      regRdValid && regRdData == $past(overLimitCode)) else $error("bad read");
   a_mv_one: assert property (
      !rangeScalingSelect |=> underLimitMv ==
      BASE_1X_MV + STEP_1X_MV * $past(underLimitCode)) else $error("bad 1x");
   a_mv_four: assert property (
      rangeScalingSelect |=> overLimitMv ==
      BASE_4X_MV + STEP_4X_MV * $past(overLimitCode)) else $error("bad 4x");
   a_under_fast: assert property (
      (flt_r[3:0] == 4'h0 && underCompare) [*5] |=> underFault)
      else $error("under fault late");
   a_over_settle: assert property (
      $rose(overFault) |-> run_r >=
      (16'h0004 << (flt_r[7:4] > 4'h9 ? 4'ha : flt_r[7:4])))
      else $error("over fault early");
   a_under_hold: assert property (
      $fell(underFault) |-> !$past(underCompare)) else $error("under drop");
endmodule
bind channel_window_threshold_debounce cwtd_monitor u_cwtd_monitor (
   .clk(clk),
   .reset_n(reset_n),
   .regAddr(regAddr),
   .regWrEn(regWrEn),
   .regWrData(regWrData),
   .regRdEn(regRdEn),
   .regRdData(regRdData),
   .regRdValid(regRdValid),
   .rangeScalingSelect(rangeScalingSelect),
   .overCompare(overCompare),
   .underCompare(underCompare),
   .overFault(overFault),
   .underFault(underFault),
   .underLimitCode(underLimitCode),
   .overLimitCode(overLimitCode),
   .underLimitMv(underLimitMv),
   .overLimitMv(overLimitMv)
);

// >>> tb/testbench.sv
// Bench for the channel limit and fault filter block
`timescale 1ns/100ps
module testbench;
   import cwtd_pkg::*;
   logic clk = 0, reset_n = 0, regWrEn = 0, regRdEn = 0, regRdValid;
   logic rangeScalingSelect = 0, overCompare = 0, underCompare = 0;
   logic overFault, underFault;
   logic [7:0] regAddr = 0, regWrData = 0, regRdData;
   logic [7:0] underLimitCode, overLimitCode;
   logic [MV_W-1:0] underLimitMv, overLimitMv;
   int mismatches = 0, nTests = 0, cycles = 0;
   channel_window_threshold_debounce u_channel_window_threshold_debounce (
      .clk(clk),
      .reset_n(reset_n),
      .regAddr(regAddr),
      .regWrEn(regWrEn),
      .regWrData(regWrData),
      .regRdEn(regRdEn),
      .regRdData(regRdData),
      .regRdValid(regRdValid),
      .rangeScalingSelect(rangeScalingSelect),
      .overCompare(overCompare),
      .underCompare(underCompare),
      .overFault(overFault),
      .underFault(underFault),
      .underLimitCode(underLimitCode),
      .overLimitCode(overLimitCode),
      .underLimitMv(underLimitMv),
      .overLimitMv(overLimitMv)
   );
   // Clock and hang guard
   initial forever #12.5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         conclude();
      end
   end
   task automatic conclude();
      if (mismatches == 0 && nTests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(string what, logic [15:0] seen, exp);
      nTests++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(logic [7:0] a, d);
      regAddr = a;
      regWrData = d;
      regWrEn = 1;
      @(negedge clk);
      regWrEn = 0;
      @(negedge clk);
   endtask
   task automatic rd(logic [7:0] a, exp);
      regAddr = a;
      regRdEn = 1;
      @(negedge clk);
      regRdEn = 0;
      chk("valid", regRdValid, 1);
      chk("rdata", regRdData, exp);
      @(negedge clk);
      chk("valid off", regRdValid, 0);
      chk("rdata held", regRdData, exp);
   endtask
   task automatic hold(logic v, int n, logic [1:0] exp);
      overCompare = v;
      underCompare = v;
      repeat (n) @(negedge clk);
      chk("faults", {overFault, underFault}, exp);
   endtask
   // Limits, unmapped place, mapping at both scales
   task automatic scRegs();
      wr(ADDR_UNDER, 8'h01);
      wr(ADDR_OVER, 8'hff);
      wr(8'h60, 8'h5a);
      chk("uCode", underLimitCode, 8'h01);
      chk("oCode", overLimitCode, 8'hff);
      rd(ADDR_UNDER, 8'h01);
      rd(ADDR_OVER, 8'hff);
      rd(8'h60, READ_UNMAPPED);
      chk("uMv", underLimitMv, 16'h00cd);
      chk("oMv", overLimitMv, 16'h05c3);
      rangeScalingSelect = 1;
      repeat (2) @(negedge clk);
      chk("uMv4", underLimitMv, 16'h0334);
      chk("oMv4", overLimitMv, 16'h170c);
      wr(ADDR_FILT, 8'ha5);
      rd(ADDR_FILT, 8'ha5);
   endtask
   // Glitch, restart, release, field split and capped codes
   task automatic scFilter();
      wr(ADDR_FILT, 8'h00);
      hold(1, 3, 2'b00);
      hold(0, 1, 2'b00);
      hold(1, 3, 2'b00);
      hold(1, 1, 2'b00);
      hold(1, 1, 2'b11);
      hold(0, 3, 2'b11);
      hold(0, 1, 2'b11);
      hold(0, 1, 2'b00);
      wr(ADDR_FILT, 8'h31);
      hold(1, 8, 2'b00);
      hold(1, 1, 2'b01);
      hold(1, 23, 2'b01);
      hold(1, 1, 2'b11);
      hold(0, 32, 2'b10);
      hold(0, 1, 2'b00);
      wr(ADDR_FILT, 8'hfa);
      hold(1, 4096, 2'b00);
      hold(1, 1, 2'b11);
   endtask
   initial begin
      repeat (12) @(negedge clk);
      reset_n = 1;
      scRegs();
      scFilter();
      conclude();
   end
endmodule
